// *** mhc_counter.sv ***
// The implementer's own choices: the Wishbone register port and the register offsets.
`timescale 1ns/1ps
`include "mhc_defs.svh"
// Functional notes
// RULE1 - Restart edge clears due and reloads remaining time; runtime untouched.
// RULE2 - Restart-all edge clears due, zeroes runtime, reloads remaining time.
// RULE3 - Run high advances runtime and lowers remaining time; run low holds both.
// RULE4 - Due goes high once remaining time equals zero.
// RULE5 - Resets-only mode: due cleared only by either restart input.
// RULE6 - Resets-or-idle mode: due also cleared while run is low.
// RULE7 - Runtime keeps counting during restart input activity.
// RULE8 - Runtime saturates at 99999 hours and stops.
// RULE9 - Interval held as hours 0..9999 plus minutes 0..59, minute resolution.
// RULE10 - Runtime accepts a preset start value, hours 0..99999 plus minutes.
// RULE11 - Interval, remaining time and runtime are retentive state. The code reloads their reset values on every rst_n assertion.
// RULE12 - Interval comes from stored constant or a live input.
// RULE13 - One-minute tick from a prescaler steps both counters.
// RULE14 - Remaining time stops at zero until reloaded.
module mhc_counter #(
    parameter int unsigned TICK_PERIOD = `MHC_MINUTE_S * `MHC_CLOCK_HZ
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Wishbone slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // Monitored run and restart inputs
    input wire logic run_in,
    input wire logic restart_in,
    input wire logic restart_all_in,
    // Live interval from another function block
    input wire mhc_pkg::mhc_si_hours_t live_hours_in,
    input wire mhc_pkg::mhc_minutes_t live_minutes_in,
    // Outputs
    output logic due_out,
    output logic irq_out
);
    import mhc_pkg::*;

    generate
        if (TICK_PERIOD < 2) begin : g_bad_tick
            $error("mhc_counter: TICK_PERIOD must be at least 2");
        end
    endgenerate

    function automatic logic [31:0] merge_bytes(input logic [31:0] old, input logic [31:0] dat,
                                                input logic [3:0] sel);
        logic [31:0] res;
        res = old;
        for (int i = 0; i < 4; i++) begin
            if (sel[i]) begin
                res[i*8 +: 8] = dat[i*8 +: 8];
            end
        end
        return res;
    endfunction

    function automatic mhc_minutes_t clamp_minutes(input mhc_minutes_t m);
        return (m > `MHC_MIN_MAX) ? `MHC_MIN_MAX : m;
    endfunction

    function automatic logic [31:0] time_word(input logic [16:0] h, input mhc_minutes_t m);
        logic [31:0] w;
        w = '0;
        w[`MHC_RT_HRS_MSB:0] = h;
        w[`MHC_MIN_MSB:`MHC_MIN_LSB] = m;
        return w;
    endfunction

    // Minute prescaler
    logic tick;

    mhc_tick #(
        .PERIOD(TICK_PERIOD)
    ) u_tick (
        .clk(clk),
        .rst_n(rst_n),
        .tick(tick) // RULE13
    );

    // Bus front end
    mhc_bus_state_t bus_reg;
    mhc_bus_state_t bus_next;
    logic [31:0] dat_reg;
    logic [31:0] dat_next;
    logic bus_req;
    logic wr_go;

    // Registers reached by software
    mhc_clear_mode_t mode_reg;
    mhc_clear_mode_t mode_next;
    logic src_reg;
    logic src_next;
    mhc_si_hours_t si_h_reg;
    mhc_si_hours_t si_h_next;
    mhc_minutes_t si_m_reg;
    mhc_minutes_t si_m_next;
    logic [`MHC_IRQ_W-1:0] irq_stat_reg;
    logic [`MHC_IRQ_W-1:0] irq_stat_next;
    logic [`MHC_IRQ_W-1:0] irq_mask_reg;
    logic [`MHC_IRQ_W-1:0] irq_mask_next;

    // Counting state
    mhc_si_hours_t rem_h_reg;
    mhc_si_hours_t rem_h_next;
    mhc_minutes_t rem_m_reg;
    mhc_minutes_t rem_m_next;
    mhc_rt_hours_t rt_h_reg;
    mhc_rt_hours_t rt_h_next;
    mhc_minutes_t rt_m_reg;
    mhc_minutes_t rt_m_next;
    logic due_reg;
    logic due_next;
    logic restart_prev_reg;
    logic restart_all_prev_reg;

    // Decoded events
    logic wr_ctrl;
    logic wr_rt;
    logic restart_edge;
    logic restart_all_edge;
    logic restart_any;
    logic rem_zero;
    logic rt_sat;
    logic idle_clear;
    mhc_si_hours_t si_hours;
    mhc_minutes_t si_minutes;
    logic [31:0] ctrl_wr;
    logic [31:0] rt_wr;

    assign bus_req = wb_cyc_i && wb_stb_i;
    // Write lands on the edge where the master sees ack
    assign wr_go = bus_req && wb_we_i && (bus_reg == MHC_BUS_ACK);
    assign wr_ctrl = wr_go && (wb_adr_i == `MHC_ADR_CTRL);
    assign wr_rt = wr_go && (wb_adr_i == `MHC_ADR_RUNTIME);
    assign ctrl_wr = merge_bytes(32'h00000000, wb_dat_i, wb_sel_i);
    assign rt_wr = merge_bytes(time_word(rt_h_reg, rt_m_reg), wb_dat_i, wb_sel_i);

    // Both restarts act on the rising edge only; software strobes alias them
    assign restart_edge = (restart_in && !restart_prev_reg) || (wr_ctrl && ctrl_wr[`MHC_CTRL_RESTART]); // RULE1
    assign restart_all_edge = (restart_all_in && !restart_all_prev_reg)
                              || (wr_ctrl && ctrl_wr[`MHC_CTRL_RESTART_ALL]); // RULE2
    assign restart_any = restart_edge || restart_all_edge;

    // Live value clamped so a bad upstream value cannot break the range
    assign si_hours = src_reg ? ((live_hours_in > `MHC_SI_HRS_MAX) ? `MHC_SI_HRS_MAX : live_hours_in)
                              : si_h_reg; // RULE12 RULE9
    assign si_minutes = src_reg ? clamp_minutes(live_minutes_in) : si_m_reg; // RULE12 RULE9

    assign rem_zero = (rem_h_reg == '0) && (rem_m_reg == `MHC_MIN_ZERO_V);
    assign rt_sat = (rt_h_reg >= `MHC_RT_HRS_MAX); // RULE8
    assign idle_clear = (mode_reg == MHC_CLEAR_BY_RESETS_OR_IDLE) && !run_in; // RULE6

    // Remaining time, runtime and due output
    always_comb begin
        rem_h_next = rem_h_reg;
        rem_m_next = rem_m_reg;
        rt_h_next = rt_h_reg;
        rt_m_next = rt_m_reg;
        if (restart_any) begin
            rem_h_next = si_hours; // RULE1 RULE2
            rem_m_next = si_minutes;
        end else if (tick && run_in && !rem_zero) begin // RULE3 RULE13 RULE14
            if (rem_m_reg == `MHC_MIN_ZERO_V) begin
                rem_m_next = `MHC_MIN_MAX;
                rem_h_next = rem_h_reg - 14'h0001;
            end else begin
                rem_m_next = rem_m_reg - 6'h01;
            end
        end
        if (restart_all_edge) begin
            rt_h_next = '0; // RULE2
            rt_m_next = `MHC_MIN_ZERO_V;
        end else if (wr_rt) begin
            rt_h_next = (rt_wr[`MHC_RT_HRS_MSB:0] > `MHC_RT_HRS_MAX) ? `MHC_RT_HRS_MAX
                                                                     : rt_wr[`MHC_RT_HRS_MSB:0]; // RULE10
            rt_m_next = clamp_minutes(rt_wr[`MHC_MIN_MSB:`MHC_MIN_LSB]);
        end else if (tick && run_in && !rt_sat) begin // RULE3 RULE7 RULE8
            if (rt_m_reg == `MHC_MIN_MAX) begin
                rt_m_next = `MHC_MIN_ZERO_V;
                rt_h_next = rt_h_reg + 17'h00001;
            end else begin
                rt_m_next = rt_m_reg + 6'h01;
            end
        end
        if (restart_any) begin
            due_next = 1'b0; // RULE1 RULE2 RULE5
        end else if (idle_clear) begin
            due_next = 1'b0; // RULE6
        end else if (rem_zero) begin
            due_next = 1'b1; // RULE4
        end else begin
            due_next = due_reg;
        end
    end

    // Counter values live in ordinary flops; every rst_n assertion reloads their reset values
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            rem_h_reg <= `MHC_SI_HRS_RST; // RULE11
            rem_m_reg <= `MHC_MIN_RST;
            rt_h_reg <= `MHC_RT_HRS_RST;
            rt_m_reg <= `MHC_MIN_RST;
            due_reg <= 1'b0;
            restart_prev_reg <= 1'b0;
            restart_all_prev_reg <= 1'b0;
        end else begin
            rem_h_reg <= rem_h_next;
            rem_m_reg <= rem_m_next;
            rt_h_reg <= rt_h_next;
            rt_m_reg <= rt_m_next;
            due_reg <= due_next;
            restart_prev_reg <= restart_in;
            restart_all_prev_reg <= restart_all_in;
        end
    end

    // Software registers and interrupt status
    always_comb begin
        logic [31:0] w;
        w = merge_bytes(time_word({3'h0, si_h_reg}, si_m_reg), wb_dat_i, wb_sel_i);
        mode_next = mode_reg;
        src_next = src_reg;
        si_h_next = si_h_reg;
        si_m_next = si_m_reg;
        irq_mask_next = irq_mask_reg;
        irq_stat_next = irq_stat_reg;
        if (wr_ctrl && wb_sel_i[0]) begin
            mode_next = mhc_clear_mode_t'(wb_dat_i[`MHC_CTRL_MODE]);
            src_next = wb_dat_i[`MHC_CTRL_SRC]; // RULE12
        end
        if (wr_go && (wb_adr_i == `MHC_ADR_INTERVAL)) begin
            si_h_next = (w[`MHC_SI_HRS_MSB:0] > `MHC_SI_HRS_MAX) ? `MHC_SI_HRS_MAX
                                                                 : w[`MHC_SI_HRS_MSB:0]; // RULE9
            si_m_next = clamp_minutes(w[`MHC_MIN_MSB:`MHC_MIN_LSB]);
        end
        if (wr_go && (wb_adr_i == `MHC_ADR_IRQ_MASK) && wb_sel_i[0]) begin
            irq_mask_next = wb_dat_i[`MHC_IRQ_W-1:0];
        end
        if (wr_go && (wb_adr_i == `MHC_ADR_IRQ_STAT) && wb_sel_i[0]) begin
            irq_stat_next = irq_stat_reg & ~wb_dat_i[`MHC_IRQ_W-1:0];
        end
        // Set after clear so a same-cycle event is never lost
        if (due_next && !due_reg) begin
            irq_stat_next[`MHC_IRQ_DUE] = 1'b1;
        end
        if ((rt_h_next >= `MHC_RT_HRS_MAX) && !rt_sat) begin
            irq_stat_next[`MHC_IRQ_SAT] = 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            mode_reg <= MHC_CLEAR_BY_RESETS;
            src_reg <= 1'b0;
            si_h_reg <= `MHC_SI_HRS_RST; // RULE11
            si_m_reg <= `MHC_MIN_RST;
            irq_mask_reg <= `MHC_MASK_RST;
            irq_stat_reg <= '0;
        end else begin
            mode_reg <= mode_next;
            src_reg <= src_next;
            si_h_reg <= si_h_next;
            si_m_reg <= si_m_next;
            irq_mask_reg <= irq_mask_next;
            irq_stat_reg <= irq_stat_next;
        end
    end

    // Bus handshake and read data, one wait state
    always_comb begin
        bus_next = MHC_BUS_IDLE;
        dat_next = dat_reg;
        if (bus_req && (bus_reg == MHC_BUS_IDLE)) begin
            bus_next = MHC_BUS_ACK;
            if (wb_adr_i == `MHC_ADR_CTRL) begin
                dat_next = 32'h00000000;
                dat_next[`MHC_CTRL_MODE] = mode_reg;
                dat_next[`MHC_CTRL_SRC] = src_reg;
            end else if (wb_adr_i == `MHC_ADR_INTERVAL) begin
                dat_next = time_word({3'h0, si_hours}, si_minutes);
            end else if (wb_adr_i == `MHC_ADR_RUNTIME) begin
                dat_next = time_word(rt_h_reg, rt_m_reg);
            end else if (wb_adr_i == `MHC_ADR_REMAIN) begin
                dat_next = time_word({3'h0, rem_h_reg}, rem_m_reg);
            end else if (wb_adr_i == `MHC_ADR_STATE) begin
                dat_next = 32'h00000000;
                dat_next[`MHC_STATE_DUE] = due_reg;
                dat_next[`MHC_STATE_RUN] = run_in;
                dat_next[`MHC_STATE_SAT] = rt_sat;
            end else if (wb_adr_i == `MHC_ADR_IRQ_STAT) begin
                dat_next = {30'h00000000, irq_stat_reg};
            end else if (wb_adr_i == `MHC_ADR_IRQ_MASK) begin
                dat_next = {30'h00000000, irq_mask_reg};
            end else begin
                dat_next = 32'h00000000;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            bus_reg <= MHC_BUS_IDLE;
            dat_reg <= 32'h00000000;
        end else begin
            bus_reg <= bus_next;
            dat_reg <= dat_next;
        end
    end

    assign wb_ack_o = (bus_reg == MHC_BUS_ACK);
    assign wb_dat_o = dat_reg;
    assign due_out = due_reg;
    assign irq_out = |(irq_stat_reg & irq_mask_reg);

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_n);

    a_restart_reload: assert property (restart_edge && !restart_all_edge
        |=> rem_h_reg == $past(si_hours) && rem_m_reg == $past(si_minutes) && !due_reg) // RULE1
        else $error("restart did not reload remaining time");
    a_clear_all_zero: assert property (restart_all_edge
        |=> rt_h_reg == '0 && rt_m_reg == `MHC_MIN_ZERO_V && !due_reg) // RULE2
        else $error("restart-all did not clear runtime and due");
    a_idle_holds_counts: assert property (!run_in && !restart_any && !wr_rt
        |=> $stable(rt_h_reg) && $stable(rt_m_reg) && $stable(rem_h_reg) && $stable(rem_m_reg)) // RULE3
        else $error("counters moved while run was low");
    a_due_on_zero: assert property (rem_zero && !restart_any && !idle_clear |=> due_reg) // RULE4
        else $error("due not raised at zero remaining time");
    a_due_held_resets: assert property (mode_reg == MHC_CLEAR_BY_RESETS && due_reg && !restart_any
        |=> due_reg) // RULE5
        else $error("due dropped without a restart");
    a_idle_clears_due: assert property (idle_clear && !restart_any |=> !due_reg) // RULE6
        else $error("due not cleared while idle");
    a_runtime_under_restart: assert property (tick && run_in && restart_edge && !restart_all_edge
        && !rt_sat && !wr_rt |=> {rt_h_reg, rt_m_reg} != $past({rt_h_reg, rt_m_reg})) // RULE7
        else $error("runtime stalled during restart");
    a_runtime_saturates: assert property (rt_sat && !restart_all_edge && !wr_rt
        |=> rt_h_reg == $past(rt_h_reg) && rt_m_reg == $past(rt_m_reg)) // RULE8
        else $error("runtime moved past its limit");
    a_interval_range: assert property (si_hours <= `MHC_SI_HRS_MAX && si_minutes <= `MHC_MIN_MAX) // RULE9
        else $error("interval out of range");
    a_step_on_tick: assert property (!tick && !restart_any
        |=> $stable(rem_h_reg) && $stable(rem_m_reg)) // RULE13
        else $error("remaining time stepped without a tick");
    a_remain_no_wrap: assert property (rem_zero && !restart_any
        |=> rem_h_reg == '0 && rem_m_reg == `MHC_MIN_ZERO_V) // RULE14
        else $error("remaining time wrapped below zero");
endmodule // mhc_counter

// *** mhc_defs.svh ***
`ifndef MHC_DEFS_SVH
`define MHC_DEFS_SVH

// Timing
`define MHC_CLOCK_HZ 10000000
`define MHC_MINUTE_S 60

// Register byte offsets
`define MHC_ADR_CTRL 8'h00
`define MHC_ADR_INTERVAL 8'h04
`define MHC_ADR_RUNTIME 8'h08
`define MHC_ADR_REMAIN 8'h0C
`define MHC_ADR_STATE 8'h10
`define MHC_ADR_IRQ_STAT 8'h14
`define MHC_ADR_IRQ_MASK 8'h18

// Control bits
`define MHC_CTRL_MODE 0
`define MHC_CTRL_SRC 1
`define MHC_CTRL_RESTART 2
`define MHC_CTRL_RESTART_ALL 3

// State bits
`define MHC_STATE_DUE 0
`define MHC_STATE_RUN 1
`define MHC_STATE_SAT 2

// Interrupt bits
`define MHC_IRQ_DUE 0
`define MHC_IRQ_SAT 1
`define MHC_IRQ_W 2

// Time word layout: hours low, minutes from bit 24
`define MHC_MIN_LSB 24
`define MHC_MIN_MSB 29
`define MHC_SI_HRS_MSB 13
`define MHC_RT_HRS_MSB 16

// Limits
`define MHC_SI_HRS_MAX 14'h270F
`define MHC_RT_HRS_MAX 17'h1869F
`define MHC_MIN_MAX 6'h3B
`define MHC_MIN_ZERO_V 6'h00

// Reset values
`define MHC_SI_HRS_RST 14'h0064
`define MHC_MIN_RST 6'h00
`define MHC_RT_HRS_RST 17'h00000
`define MHC_CTRL_RST 2'h0
`define MHC_MASK_RST 2'h0

`endif

// *** mhc_pkg.sv ***
package mhc_pkg;

    typedef enum logic [0:0] {
        MHC_BUS_IDLE = 1'b0,
        MHC_BUS_ACK = 1'b1
    } mhc_bus_state_t;

    typedef enum logic [0:0] {
        MHC_CLEAR_BY_RESETS = 1'b0,
        MHC_CLEAR_BY_RESETS_OR_IDLE = 1'b1
    } mhc_clear_mode_t;

    typedef logic [5:0] mhc_minutes_t;
    typedef logic [13:0] mhc_si_hours_t;
    typedef logic [16:0] mhc_rt_hours_t;

endpackage

// *** mhc_tick.sv ***
`timescale 1ns/1ps
module mhc_tick #(
    parameter int unsigned PERIOD = 600000000
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Minute strobe
    output logic tick
);
    localparam int W = $clog2(PERIOD);

    logic [W-1:0] count_reg;
    logic [W-1:0] count_next;
    logic tick_reg;
    logic tick_next;

    generate
        if (PERIOD < 2) begin : g_bad_period
            $error("mhc_tick: PERIOD must be at least 2");
        end
    endgenerate

    always_comb begin
        tick_next = (count_reg == W'(PERIOD - 1));
        count_next = tick_next ? '0 : count_reg + W'(1);
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            count_reg <= '0;
            tick_reg <= 1'b0;
        end else begin
            count_reg <= count_next;
            tick_reg <= tick_next;
        end
    end

    assign tick = tick_reg;
endmodule // mhc_tick

// *** mhc_plant.sv ***
`timescale 1ns/1ps
module mhc_plant (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Requests from the sequence
    input wire logic run_req,
    input wire logic restart_req,
    input wire logic restart_all_req,
    // Device side
    input wire logic due_out,
    output logic run_in,
    output logic restart_in,
    output logic restart_all_in,
    output logic [7:0] due_rises
);
    logic due_last;
    // Pins change only on the clock, as a synchronous plant would drive them
    always_ff @(posedge clk) begin
        run_in <= rst_n & run_req;
        restart_in <= rst_n & restart_req;
        restart_all_in <= rst_n & restart_all_req;
        due_last <= rst_n & due_out;
        if (!rst_n) begin
            due_rises <= 8'h00;
        end else if (due_out && !due_last) begin
            due_rises <= due_rises + 8'h01;
        end
    end
endmodule // mhc_plant

// *** maintenance_hours_counter_tb.sv ***
`timescale 1ns/1ps
`include "mhc_defs.svh"
module maintenance_hours_counter_tb;
    import mhc_pkg::*;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic cyc = 1'b0, stb = 1'b0, we = 1'b0;
    logic [7:0] adr = 8'h00;
    logic [3:0] sel = 4'h0;
    logic [31:0] wdat = 32'h00000000, rd, t0;
    logic [31:0] rdat;
    logic ack, due_out, irq_out, run_in, restart_in, restart_all_in;
    logic run_req = 1'b0, rs_req = 1'b0, rsa_req = 1'b0;
    logic [7:0] due_rises;
    mhc_si_hours_t live_hours = 14'h0000;
    mhc_minutes_t live_minutes = 6'h00;
    int n_errors = 0;
    int total_checks = 0;

    always #50 clk = ~clk;

    // Short prescaler so a minute is four clocks
    mhc_counter #(.TICK_PERIOD(4)) u_mhc_counter (.clk(clk), .rst_n(rst_n), .wb_cyc_i(cyc), .wb_stb_i(stb),
        .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
        .run_in(run_in), .restart_in(restart_in), .restart_all_in(restart_all_in),
        .live_hours_in(live_hours), .live_minutes_in(live_minutes), .due_out(due_out), .irq_out(irq_out));
    mhc_plant u_mhc_plant (.clk(clk), .rst_n(rst_n), .run_req(run_req), .restart_req(rs_req),
        .restart_all_req(rsa_req), .due_out(due_out), .run_in(run_in), .restart_in(restart_in),
        .restart_all_in(restart_all_in), .due_rises(due_rises));

    task automatic report_and_stop();
        $display("checks %0d errors %0d", total_checks, n_errors);
        if (n_errors == 0 && total_checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("ERROR %s expected %h seen %h", name, exp, seen);
        end
    endtask

    // Hold the request until ack is sampled high, then release
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= d;
        sel <= 4'hF;
        do begin
            @(posedge clk);
            n++;
        end while (ack !== 1'b1 && n < 50);
        if (n >= 50) chk("wb_ack", ack, 32'h1);
        rd = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
        we <= 1'b0;
    endtask

    task automatic rchk(input string name, input logic [7:0] a, input logic [31:0] exp);
        wb(1'b0, a, 32'h0);
        chk(name, rd, exp);
    endtask

    task automatic pins(input logic r, input int n);
        @(posedge clk);
        run_req <= r;
        repeat (n) @(posedge clk);
    endtask

    task automatic pulse(input logic all);
        @(posedge clk);
        if (all) rsa_req <= 1'b1;
        else rs_req <= 1'b1;
        repeat (3) @(posedge clk);
        rs_req <= 1'b0;
        rsa_req <= 1'b0;
        repeat (3) @(posedge clk);
    endtask

    task automatic wait_due(input logic v);
        int n;
        n = 0;
        while (due_out !== v && n < 300) begin
            @(posedge clk);
            n++;
        end
        chk("due_out", due_out, v);
    endtask

    task automatic t_reset_values();
        rchk("ctrl", `MHC_ADR_CTRL, 32'h0);
        rchk("interval", `MHC_ADR_INTERVAL, 32'h00000064);
        rchk("runtime", `MHC_ADR_RUNTIME, 32'h0);
        rchk("remain", `MHC_ADR_REMAIN, 32'h00000064);
        rchk("state", `MHC_ADR_STATE, 32'h0);
        rchk("irq_stat", `MHC_ADR_IRQ_STAT, 32'h0);
        rchk("irq_mask", `MHC_ADR_IRQ_MASK, 32'h0);
        rchk("unmapped", 8'h1C, 32'h0);
        chk("irq_out", irq_out, 32'h0);
    endtask

    task automatic t_count_due();
        wb(1'b1, `MHC_ADR_INTERVAL, 32'h3F003FFF);
        rchk("interval clamp", `MHC_ADR_INTERVAL, 32'h3B00270F);
        wb(1'b1, `MHC_ADR_INTERVAL, 32'h02000000);
        wb(1'b1, `MHC_ADR_CTRL, 32'h00000004);
        rchk("remain load", `MHC_ADR_REMAIN, 32'h02000000);
        pins(1'b1, 0);
        wait_due(1'b1);
        rchk("remain zero", `MHC_ADR_REMAIN, 32'h0);
        wb(1'b0, `MHC_ADR_RUNTIME, 32'h0);
        chk("runtime advanced", 32'(rd >= 32'h02000000), 32'h1);
        chk("due consumer", due_rises, 32'h1);
        rchk("irq due", `MHC_ADR_IRQ_STAT, 32'h1);
        wb(1'b1, `MHC_ADR_IRQ_MASK, 32'h1);
        @(posedge clk);
        chk("irq_out on", irq_out, 32'h1);
        wb(1'b1, `MHC_ADR_IRQ_STAT, 32'h1);
        @(posedge clk);
        chk("irq_out cleared", irq_out, 32'h0);
        pins(1'b0, 3);
        wb(1'b0, `MHC_ADR_RUNTIME, 32'h0);
        t0 = rd;
        repeat (20) @(posedge clk);
        rchk("runtime hold", `MHC_ADR_RUNTIME, t0);
        rchk("remain stays", `MHC_ADR_REMAIN, 32'h0);
        chk("due kept", due_out, 32'h1);
    endtask

    task automatic t_restarts();
        pulse(1'b0);
        chk("due after restart", due_out, 32'h0);
        rchk("remain reload", `MHC_ADR_REMAIN, 32'h02000000);
        rchk("runtime kept", `MHC_ADR_RUNTIME, t0);
        pins(1'b1, 0);
        wait_due(1'b1);
        pins(1'b0, 3);
        pulse(1'b1);
        chk("due after restart all", due_out, 32'h0);
        rchk("runtime zero", `MHC_ADR_RUNTIME, 32'h0);
        rchk("remain reload all", `MHC_ADR_REMAIN, 32'h02000000);
    endtask

    task automatic t_idle_clear();
        wb(1'b1, `MHC_ADR_CTRL, 32'h1);
        pins(1'b1, 0);
        wait_due(1'b1);
        pins(1'b0, 4);
        chk("due idle clear", due_out, 32'h0);
        wb(1'b1, `MHC_ADR_CTRL, 32'h0);
    endtask

    task automatic t_run_during_restart();
        pins(1'b1, 2);
        wb(1'b0, `MHC_ADR_RUNTIME, 32'h0);
        t0 = rd;
        rs_req <= 1'b1;
        repeat (30) @(posedge clk);
        rs_req <= 1'b0;
        wb(1'b0, `MHC_ADR_RUNTIME, 32'h0);
        chk("runtime during restart", 32'(rd > t0), 32'h1);
        // Reloaded interval runs out during the long restart level, so due is back up
        rchk("state run", `MHC_ADR_STATE, 32'h3);
        pins(1'b0, 3);
    endtask

    task automatic t_saturate();
        wb(1'b1, `MHC_ADR_RUNTIME, 32'h3F01FFFF);
        rchk("preset clamp", `MHC_ADR_RUNTIME, 32'h3B01869F);
        wb(1'b1, `MHC_ADR_RUNTIME, 32'h3B01869E);
        rchk("preset", `MHC_ADR_RUNTIME, 32'h3B01869E);
        pins(1'b1, 40);
        pins(1'b0, 3);
        rchk("runtime limit", `MHC_ADR_RUNTIME, 32'h0001869F);
        wb(1'b0, `MHC_ADR_STATE, 32'h0);
        chk("sat flag", rd[2], 32'h1);
        wb(1'b0, `MHC_ADR_IRQ_STAT, 32'h0);
        chk("irq sat", rd[1], 32'h1);
        wb(1'b1, `MHC_ADR_IRQ_MASK, 32'h2);
        @(posedge clk);
        chk("irq_out sat", irq_out, 32'h1);
        wb(1'b1, `MHC_ADR_IRQ_STAT, 32'h2);
        @(posedge clk);
        chk("irq_out sat clear", irq_out, 32'h0);
    endtask

    task automatic t_live_interval();
        @(posedge clk);
        live_hours <= 14'h0005;
        live_minutes <= 6'h07;
        wb(1'b1, `MHC_ADR_CTRL, 32'h2);
        rchk("live interval", `MHC_ADR_INTERVAL, 32'h07000005);
        pulse(1'b0);
        rchk("live reload", `MHC_ADR_REMAIN, 32'h07000005);
        live_hours <= 14'h3FFF;
        live_minutes <= 6'h3F;
        rchk("live clamp", `MHC_ADR_INTERVAL, 32'h3B00270F);
        wb(1'b1, `MHC_ADR_CTRL, 32'h0);
        rchk("stored again", `MHC_ADR_INTERVAL, 32'h02000000);
    endtask

    initial begin
        #(100 * 20000);
        n_errors++;
        report_and_stop();
    end

    initial begin
        repeat (8) @(posedge clk);
        rst_n <= 1'b1;
        t_reset_values();
        t_count_due();
        t_restarts();
        t_idle_clear();
        t_run_during_restart();
        t_saturate();
        t_live_interval();
        report_and_stop();
    end
endmodule // maintenance_hours_counter_tb
